// [common/ssg_pkg.sv]
/*
  Package for the stop-state gain scheduler: register byte offsets,
  field positions, reset values and arithmetic constants.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package ssg_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_ENABLE_BITS = 8'h00;
  localparam logic [7:0] ADDR_JUDGE_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_HALF_BITS = 8'h08;
  localparam logic [7:0] ADDR_CUT_MAG = 8'h0c;
  localparam logic [7:0] ADDR_SUPPRESS_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Field positions
  localparam int REDUCE_ENABLE_BIT = 3;
  localparam int SUPPRESS_ENABLE_BIT = 4;
  localparam int HALF_SELECT_BIT = 3;
  localparam int MODE_SWITCH_BIT = 0;
  localparam int MODE_HIGH_CYCLE_BIT = 1;
  localparam int MODE_LOCK_BIT = 2;
  // Reset values
  localparam logic [7:0] RST_ENABLE_BITS = 8'h00;
  localparam logic [15:0] RST_JUDGE_LEVEL = 16'h0005;
  localparam logic [7:0] RST_HALF_BITS = 8'h00;
  localparam logic [15:0] RST_CUT_MAG = 16'h0000;
  localparam logic [15:0] RST_SUPPRESS_LEVEL = 16'h0190;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  // Suppression level units per detection-unit pulse
  localparam logic [15:0] SUPPRESS_UNIT = 16'h0190;
  localparam logic [15:0] SUPPRESS_MAX = 16'h7fff;
  // Percent divisor for the cutting magnification
  localparam logic [15:0] PERCENT_FULL = 16'h0064;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [core/ssg_gain_scale.sv]
/*
  Combinational gain scaler: picks 75 %, 50 % or alpha/100 of a base gain.
  Assumes a 16-bit unsigned gain; alpha is a percentage.
*/
`timescale 1ns/1ps
module ssg_gain_scale
  import ssg_pkg::*;
#(
  parameter int GAIN_W = 16
) (
  input wire logic [GAIN_W-1:0] base_gain,
  input wire logic half_sel,
  input wire logic use_alpha,
  input wire logic [15:0] alpha,
  output logic [GAIN_W-1:0] scaled_gain
);
  logic [GAIN_W+15:0] product;

  // Alpha product, then divide by one hundred
  always_comb begin
    product = base_gain * alpha;
    if (use_alpha) begin
      scaled_gain = GAIN_W'(product / (GAIN_W + 16)'(PERCENT_FULL));
    end else if (half_sel) begin
      scaled_gain = base_gain >> 1;
    end else begin
      scaled_gain = GAIN_W'((base_gain >> 1) + (base_gain >> 2));
    end
  end
endmodule // ssg_gain_scale

// [core/ssg_pulse_filter.sv]
/*
  Small-motion pulse suppression: drops feedback pulses made while the
  motor returns inside the rest grid. The grid width is the level
  parameter, 400 per detection-unit pulse.
  Assumes signed feedback increments, one per clock.
*/
`timescale 1ns/1ps
module ssg_pulse_filter
  import ssg_pkg::*;
#(
  parameter int FB_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic at_rest,
  input wire logic [15:0] level,
  input wire logic signed [FB_W-1:0] fb_in,
  output logic signed [FB_W-1:0] fb_out,
  output logic dropping
);
  // Grid position in level units (400 per pulse)
  logic signed [31:0] grid_pos;
  logic signed [31:0] next_grid_pos;
  logic signed [31:0] step;
  logic signed [31:0] cand;
  logic in_grid;

  // Grid tracking and pulse exclusion
  always_comb begin
    step = 32'(fb_in) * $signed({16'h0000, SUPPRESS_UNIT});
    cand = grid_pos + step;
    in_grid = (cand <= $signed({16'h0000, level})) &&
              (cand >= -$signed({16'h0000, level}));
    next_grid_pos = grid_pos;
    fb_out = fb_in;
    dropping = 1'b0;
    if (enable && at_rest) begin
      if (in_grid) begin
        next_grid_pos = cand;
        fb_out = '0;
        dropping = (fb_in != '0);
      end else begin
        next_grid_pos = '0;
      end
    end else begin
      next_grid_pos = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grid_pos <= '0;
    end else begin
      grid_pos <= next_grid_pos;
    end
  end
endmodule // ssg_pulse_filter

// [core/ssg_scheduler.sv]
/*
  Top of the stop-state gain scheduler: AXI4-Lite register slave, stop
  detection, gain selection and small-motion pulse suppression.
  Assumes one clock, synchronous active-low reset, and servo inputs that
  arrive from logic on the same clock.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ssg_scheduler
  import ssg_pkg::*;
#(
  parameter int GAIN_W = 16,
  parameter int ERR_W = 24,
  parameter int FB_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [ERR_W-1:0] position_error,
  input wire logic cutting_mode,
  input wire logic [GAIN_W-1:0] velocity_proportional_gain,
  input wire logic [GAIN_W-1:0] rapid_gain,
  input wire logic signed [FB_W-1:0] feedback_in,
  output logic [GAIN_W-1:0] gain_out,
  output logic signed [FB_W-1:0] feedback_out,
  output logic stop_gain_reduce_on
);
  import ssg_pkg::*;
  default clocking chk_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  //////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] enable_bits, next_enable_bits;
  logic [15:0] judge_level, next_judge_level;
  logic [7:0] half_bits, next_half_bits;
  logic [15:0] cut_mag, next_cut_mag;
  logic [15:0] suppress_level, next_suppress_level;
  logic [7:0] mode_ctrl, next_mode_ctrl;
  logic stop_gain_reduce_enable, stop_gain_half_select;
  logic small_motion_suppress_enable;

  // AXI slave state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write, wr_hit, rd_hit;
  logic [31:0] rd_word;

  // Datapath state
  logic [GAIN_W-1:0] gain_reg, next_gain_reg;
  logic signed [FB_W-1:0] fb_reg, next_fb_reg;
  logic reduce_on, next_reduce_on;
  logic dropping, last_drop, next_last_drop;
  logic [ERR_W-1:0] abs_err;
  logic at_rest, reduce_active, use_alpha;
  logic [GAIN_W-1:0] base_gain, scaled_gain;
  logic signed [FB_W-1:0] fb_filtered;

  assign stop_gain_reduce_enable = enable_bits[REDUCE_ENABLE_BIT];
  assign small_motion_suppress_enable = enable_bits[SUPPRESS_ENABLE_BIT];
  assign stop_gain_half_select = half_bits[HALF_SELECT_BIT];

  // Byte-lane merge of a written word into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write path: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_enable_bits = enable_bits;
    next_judge_level = judge_level;
    next_half_bits = half_bits;
    next_cut_mag = cut_mag;
    next_suppress_level = suppress_level;
    next_mode_ctrl = mode_ctrl;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !bvalid;
    wr_hit = 1'b1;
    if (do_write) begin
      unique case (aw_addr)
        ADDR_ENABLE_BITS: next_enable_bits =
          8'(merge({24'h0, enable_bits}, w_data, w_strb));
        ADDR_JUDGE_LEVEL: next_judge_level =
          16'(merge({16'h0, judge_level}, w_data, w_strb));
        ADDR_HALF_BITS: next_half_bits =
          8'(merge({24'h0, half_bits}, w_data, w_strb));
        ADDR_CUT_MAG: next_cut_mag =
          16'(merge({16'h0, cut_mag}, w_data, w_strb));
        ADDR_SUPPRESS_LEVEL: next_suppress_level =
          16'(merge({16'h0, suppress_level}, w_data, w_strb))
          & SUPPRESS_MAX;
        ADDR_MODE_CTRL: next_mode_ctrl =
          8'(merge({24'h0, mode_ctrl}, w_data, w_strb));
        ADDR_STATUS: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Read path: one read at a time, answered the cycle after it is taken
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_ENABLE_BITS: rd_word = {24'h0, enable_bits};
      ADDR_JUDGE_LEVEL: rd_word = {16'h0, judge_level};
      ADDR_HALF_BITS: rd_word = {24'h0, half_bits};
      ADDR_CUT_MAG: rd_word = {16'h0, cut_mag};
      ADDR_SUPPRESS_LEVEL: rd_word = {16'h0, suppress_level};
      ADDR_MODE_CTRL: rd_word = {24'h0, mode_ctrl};
      ADDR_STATUS: rd_word = {30'h0, last_drop, reduce_on};
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_bits <= RST_ENABLE_BITS;
      judge_level <= RST_JUDGE_LEVEL;
      half_bits <= RST_HALF_BITS;
      cut_mag <= RST_CUT_MAG;
      suppress_level <= RST_SUPPRESS_LEVEL;
      mode_ctrl <= RST_MODE_CTRL;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      enable_bits <= next_enable_bits;
      judge_level <= next_judge_level;
      half_bits <= next_half_bits;
      cut_mag <= next_cut_mag;
      suppress_level <= next_suppress_level;
      mode_ctrl <= next_mode_ctrl;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_arready <= !next_rvalid;
    end
  end

  // Response outputs straight from their registers
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  //////////////////////////////////////////////////////////////////////////
  // Stop detection and gain selection
  always_comb begin
    abs_err = position_error[ERR_W-1] ? ERR_W'(-position_error)
                                      : ERR_W'(position_error);
    at_rest = abs_err < ERR_W'(judge_level);
    reduce_active = stop_gain_reduce_enable && at_rest
      && !(mode_ctrl[MODE_LOCK_BIT] && mode_ctrl[MODE_HIGH_CYCLE_BIT]);
    base_gain = (mode_ctrl[MODE_SWITCH_BIT] && !cutting_mode)
                ? rapid_gain : velocity_proportional_gain;
    use_alpha = cutting_mode && (cut_mag != 16'h0000);
    next_gain_reg = reduce_active ? scaled_gain : base_gain;
    next_reduce_on = reduce_active;
    next_fb_reg = fb_filtered;
    next_last_drop = dropping;
  end

  ssg_gain_scale #(
    .GAIN_W(GAIN_W)
  ) u_scale (
    .base_gain(base_gain),
    .half_sel(stop_gain_half_select),
    .use_alpha(use_alpha),
    .alpha(cut_mag),
    .scaled_gain(scaled_gain)
  );

  // Grid width follows the level parameter, one pulse by default
  ssg_pulse_filter #(
    .FB_W(FB_W)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(small_motion_suppress_enable),
    .at_rest(at_rest),
    .level(suppress_level),
    .fb_in(feedback_in),
    .fb_out(fb_filtered),
    .dropping(dropping)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_reg <= '0;
      fb_reg <= '0;
      reduce_on <= 1'b0;
      last_drop <= 1'b0;
    end else begin
      gain_reg <= next_gain_reg;
      fb_reg <= next_fb_reg;
      reduce_on <= next_reduce_on;
      last_drop <= next_last_drop;
    end
  end

  assign gain_out = gain_reg;
  assign feedback_out = fb_reg;
  assign stop_gain_reduce_on = reduce_on;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_disabled_full: assert property (!stop_gain_reduce_enable |=>
    gain_out == $past(base_gain)) else $error("gain cut while disabled");
  chk_rest_quarter: assert property (reduce_active && !use_alpha &&
    !stop_gain_half_select |=> gain_out == GAIN_W'(($past(base_gain) >> 1) +
    ($past(base_gain) >> 2))) else $error("stop gain not three quarters");
  chk_rest_half: assert property (reduce_active && !use_alpha &&
    stop_gain_half_select |=> gain_out == ($past(base_gain) >> 1))
    else $error("stop gain not one half");
  chk_alpha_cut: assert property (reduce_active && use_alpha |=>
    gain_out == GAIN_W'(32'($past(base_gain)) * 32'($past(cut_mag))
    / 32'(PERCENT_FULL))) else $error("cutting stop gain not alpha");
  chk_rapid_base: assert property (mode_ctrl[MODE_SWITCH_BIT] &&
    !cutting_mode |-> base_gain == rapid_gain && !use_alpha)
    else $error("rapid base gain wrong");
  chk_cut_base: assert property (cutting_mode && !reduce_active |=>
    gain_out == $past(velocity_proportional_gain))
    else $error("cutting base gain wrong");
  chk_lock_off: assert property (mode_ctrl[MODE_LOCK_BIT] &&
    mode_ctrl[MODE_HIGH_CYCLE_BIT] |=> !stop_gain_reduce_on)
    else $error("reduction active in high-cycle lock");
  chk_restore_full: assert property (!at_rest |=> !stop_gain_reduce_on
    && gain_out == $past(base_gain)) else $error("full gain not restored");
  chk_drop_zero: assert property (dropping |=> feedback_out == '0)
    else $error("suppressed pulse leaked");
  chk_drop_enable: assert property (!small_motion_suppress_enable |=>
    feedback_out == $past(feedback_in)) else $error("feedback altered");
  chk_level_max: assert property (suppress_level <= SUPPRESS_MAX)
    else $error("suppression level out of range");
  cov_reduce: cover property (@(posedge aclk) stop_gain_reduce_on);
  cov_alpha: cover property (@(posedge aclk) reduce_active && use_alpha);
  cov_drop: cover property (@(posedge aclk) dropping);
  cov_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
endmodule // ssg_scheduler

// [dv/ssg_motor_model.sv]
/*
  Behavioural motor and position detector: the far side of the scheduler.
  Assumes the bench commands the error and feedback step it wants.
  Both values are presented one clock later, like a sampled detector.
*/
`timescale 1ns/1ps
module ssg_motor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic signed [23:0] cmd_err,
  input wire logic signed [15:0] cmd_fb,
  output logic signed [23:0] position_error,
  output logic signed [15:0] feedback_in
);
  // Detector sample register; reads zero while the axis is held in reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      position_error <= '0;
      feedback_in <= '0;
    end else begin
      position_error <= cmd_err;
      feedback_in <= cmd_fb;
    end
  end
endmodule // ssg_motor_model

// [dv/testbench.sv]
/*
  Self-checking bench for the stop-state gain scheduler.
  Assumes the AXI4-Lite map and latencies of the scheduler package.
*/
`timescale 1ns/1ps
module testbench;
  import ssg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic signed [23:0] cmd_err = '0;
  logic signed [23:0] position_error;
  logic signed [15:0] cmd_fb = '0;
  logic signed [15:0] feedback_in, feedback_out;
  logic cutting_mode = 0;
  logic reduce_on;
  logic [15:0] vpg = '0, rapid = '0;
  logic [15:0] gain_out;
  int errors = 0;
  int n_tests = 0;
  logic [7:0] reg_addr [6] = '{ADDR_ENABLE_BITS, ADDR_JUDGE_LEVEL,
    ADDR_HALF_BITS, ADDR_CUT_MAG, ADDR_SUPPRESS_LEVEL, ADDR_MODE_CTRL};
  logic [15:0] reg_rst [6] = '{RST_ENABLE_BITS, RST_JUDGE_LEVEL,
    RST_HALF_BITS, RST_CUT_MAG, RST_SUPPRESS_LEVEL, RST_MODE_CTRL};

  // 25 MHz clock
  always #20 aclk = ~aclk;

  ssg_motor_model u_motor (.aclk(aclk), .aresetn(aresetn), .cmd_err(cmd_err),
    .cmd_fb(cmd_fb), .position_error(position_error),
    .feedback_in(feedback_in));

  ssg_scheduler u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .position_error(position_error), .cutting_mode(cutting_mode),
    .velocity_proportional_gain(vpg), .rapid_gain(rapid),
    .feedback_in(feedback_in), .gain_out(gain_out),
    .feedback_out(feedback_out), .stop_gain_reduce_on(reduce_on));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d of %0d compares", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master: hold each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY, "write response");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: about fifteen times the expected run
  initial begin
    #(40 * 40000);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int en, half, mag, mode, lvl, ev, base, expg, exp_red, grid, v, e, slvl;
    int q[$];
    void'($urandom(35148));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    // Reset values, unmapped place, read-only status, field widths
    for (int i = 0; i < 6; i++) begin
      rd(reg_addr[i], d, r);
      chk(d, {16'h0, reg_rst[i]}, "reset value");
    end
    rd(8'h1c, d, r);
    chk(r, RESP_SLVERR, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    wr(8'h1c, 32'hffffffff, r);
    chk(r, RESP_SLVERR, "unmapped write");
    wr(ADDR_STATUS, 32'hffffffff, r);
    rd(ADDR_STATUS, d, r);
    chk(d, 32'h0, "status read-only");
    wreg(ADDR_JUDGE_LEVEL, 32'hffff0007);
    rd(ADDR_JUDGE_LEVEL, d, r);
    chk(d, 32'h7, "judge width");
    wreg(ADDR_SUPPRESS_LEVEL, 32'h0001ffff);
    rd(ADDR_SUPPRESS_LEVEL, d, r);
    chk(d, {16'h0, SUPPRESS_MAX}, "suppress width");
    // Random gain schedules against the integer model
    for (int i = 0; i < 80; i++) begin
      en = $urandom_range(0, 1);
      half = $urandom_range(0, 1);
      mag = $urandom_range(0, 1) ? $urandom_range(25, 100) : 0;
      mode = $urandom_range(0, 7);
      lvl = $urandom_range(2, 10);
      wreg(ADDR_ENABLE_BITS, en << REDUCE_ENABLE_BIT);
      wreg(ADDR_HALF_BITS, half << HALF_SELECT_BIT);
      wreg(ADDR_CUT_MAG, mag);
      wreg(ADDR_MODE_CTRL, mode);
      wreg(ADDR_JUDGE_LEVEL, lvl);
      case ($urandom_range(0, 2))
        0: ev = $urandom_range(0, lvl - 1);
        1: ev = lvl;
        default: ev = lvl + $urandom_range(1, 1000);
      endcase
      @(posedge aclk);
      cmd_err <= $urandom_range(0, 1) ? -ev : ev;
      cutting_mode <= $urandom_range(0, 1);
      vpg <= 16'($urandom);
      rapid <= 16'($urandom);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      exp_red = en && (ev < lvl) && !(mode[2] && mode[1]);
      base = (mode[0] && !cutting_mode) ? rapid : vpg;
      if (!exp_red) expg = base;
      else if (cutting_mode && mag != 0) expg = base * mag / 100;
      else if (half) expg = base >> 1;
      else expg = (base >> 1) + (base >> 2);
      chk(reduce_on, exp_red, "reduce flag");
      chk(gain_out, expg, "scheduled gain");
      rd(ADDR_STATUS, d, r);
      chk(d[0], exp_red, "status reduce");
    end
    // Pulse suppression at rest: three levels, then disabled
    for (int p = 0; p < 4; p++) begin
      slvl = (p == 1) ? 1200 : (p == 2) ? 0 : 400;
      @(posedge aclk);
      cmd_fb <= 0;
      cmd_err <= 100;
      repeat (3) @(posedge aclk);
      wreg(ADDR_ENABLE_BITS, (p != 3) << SUPPRESS_ENABLE_BIT);
      wreg(ADDR_JUDGE_LEVEL, 5);
      wreg(ADDR_SUPPRESS_LEVEL, slvl);
      @(posedge aclk);
      cmd_err <= 0;
      repeat (3) @(posedge aclk);
      grid = 0;
      q.delete();
      for (int k = 0; k < 60; k++) begin
        v = $urandom_range(0, 2) - 1;
        @(posedge aclk);
        cmd_fb <= v;
        if (p != 3 && (grid + v * 400) <= slvl && -(grid + v * 400) <= slvl)
        begin
          e = 0;
          grid = grid + v * 400;
        end else begin
          e = v;
          grid = 0;
        end
        q.push_back(e);
        @(negedge aclk);
        if (q.size() == 3)
          chk(feedback_out, q.pop_front(), "feedback");
      end
    end
    close_out();
  end
endmodule // testbench
